//--- hdl/fbh_flash_host.v
// Host controller that drives a parallel boot-sector flash over its pins
//
// Summary of operation
// R1 - Word mode drives all sixteen data lines
// R2 - Byte mode: top line carries low address
// R3 - Address 20 bits word, 21 bits byte
// R4 - Read: select low, gate low, strobe high
// R5 - Device reads array after reset
// R6 - Array reads stay until command written
// R7 - Command latches have no address
// R8 - Write: strobe, select low, gate high
// R9 - Program data width follows width select
// R10 - Fast-program mode needs two write cycles
// R11 - Erase by sector, sectors or chip
// R12 - Identification codes on low eight lines
// R13 - Status bits on low eight lines
// R14 - Deselected device floats its outputs
// R15 - First read waits full select access
// R16 - Deselect does not stop embedded operation
// R17 - Boot-lock low protects outer sectors
// R18 - Boot-lock high keeps last protection
// R19 - Gate high floats device outputs
// R20 - Reset low aborts and floats outputs
// R21 - Device drives only during valid read
`timescale 1ns/1ps
`include "fbh_defs.vh"

module fbh_flash_host (
    input wire sys_clk, // System clock, 125 MHz
    input wire rst_n, // Asynchronous reset, active low
    input wire wb_cyc_i, // Wishbone cycle
    input wire wb_stb_i, // Wishbone strobe
    input wire wb_we_i, // Wishbone write enable
    input wire [3:0] wb_adr_i, // Wishbone byte address
    input wire [3:0] wb_sel_i, // Wishbone byte selects
    input wire [31:0] wb_dat_i, // Wishbone write data
    output reg [31:0] wb_dat_o, // Wishbone read data
    output reg wb_ack_o, // Wishbone acknowledge
    output reg [19:0] flashAddr, // Flash address lines
    output reg [14:0] flashDqOut, // Data lines 0..14 out
    output reg [14:0] flashDqOe, // Data lines 0..14 enable
    input wire [14:0] flashDqIn, // Data lines 0..14 in
    output reg topDataOrLowAddrOut, // Top data line or low address out
    output reg topDataOrLowAddrOe, // Top data line enable
    input wire topDataOrLowAddrIn, // Top data line in
    output reg chipSel_n, // Chip select, active low
    output reg outGate_n, // Output gate, active low
    output reg writeStrobe_n, // Write strobe, active low
    output reg flashReset_n, // Device reset, active low
    output reg wordSel, // Width select, high for words
    output reg bootUnlock // Boot-lock level, low protects
);

    // ------------------------------------------------------------
    // Timing counts
    // ------------------------------------------------------------
    // Whole cycle counts, worked out at full integer width
    localparam integer CE_CYC_FULL = `FBH_CYC(`FBH_T_CE_NS);
    localparam integer WP_CYC_FULL = `FBH_CYC(`FBH_T_WP_NS);
    localparam integer HOLD_CYC_FULL = `FBH_CYC(`FBH_T_HOLD_NS);
    localparam integer RP_CYC_FULL = `FBH_CYC(`FBH_T_RP_NS);
    localparam integer RH_CYC_FULL = `FBH_CYC(`FBH_T_RH_NS);

    // Cut to the counter width; every count stays below 256
    localparam [7:0] CE_CYC = CE_CYC_FULL[7:0];
    localparam [7:0] WP_CYC = WP_CYC_FULL[7:0];
    localparam [7:0] HOLD_CYC = HOLD_CYC_FULL[7:0];
    localparam [7:0] RP_CYC = RP_CYC_FULL[7:0];
    localparam [7:0] RH_CYC = RH_CYC_FULL[7:0];

    // Controller states
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_READ = 3'h1;
    localparam [2:0] ST_WRITE = 3'h2;
    localparam [2:0] ST_HOLD = 3'h3;
    localparam [2:0] ST_RST = 3'h4;
    localparam [2:0] ST_RREC = 3'h5;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg [2:0] state;
    reg [7:0] count;
    reg [`FBH_ADDR_W-1:0] addrReg;
    reg [15:0] wdataReg;
    reg [15:0] rdataReg;
    reg ctrlWrite;
    reg ctrlWord;
    reg ctrlBootUnlock;
    reg ctrlFast;
    reg goReq;
    reg rstReq;

    wire wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wbWr = wbReq & wb_we_i;
    wire busy = (state != ST_IDLE) | goReq | rstReq;

    // Data line enables for the current width
    function [14:0] dqEnable;
        input word;
        begin
            dqEnable = word ? 15'h7fff : 15'h00ff;
        end
    endfunction

    // Readback words assembled at their field positions
    reg [31:0] ctrlImage;
    reg [31:0] statImage;
    always @* begin
        ctrlImage = 32'h0;
        ctrlImage[`FBH_CTRL_WRITE] = ctrlWrite;
        ctrlImage[`FBH_CTRL_WORD] = ctrlWord;
        ctrlImage[`FBH_CTRL_BOOTLOCK] = ctrlBootUnlock;
        ctrlImage[`FBH_CTRL_FAST] = ctrlFast;
        statImage = 32'h0;
        statImage[`FBH_STAT_BUSY] = busy;
        statImage[`FBH_STAT_RDATA_LSB +: 16] = rdataReg;
    end

    // ------------------------------------------------------------
    // Wishbone slave, one wait cycle, unmapped reads zero
    // ------------------------------------------------------------
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            addrReg <= 21'h0;
            wdataReg <= 16'h0;
            ctrlWrite <= 1'b0;
            ctrlWord <= 1'b1;
            ctrlBootUnlock <= 1'b1;
            ctrlFast <= 1'b0;
            goReq <= 1'b0;
            rstReq <= 1'b0;
        end else begin
            wb_ack_o <= wbReq;
            if (state == ST_IDLE && goReq) begin
                goReq <= 1'b0;
            end
            if (state == ST_IDLE && rstReq) begin
                rstReq <= 1'b0;
            end
            if (wbReq && !wb_we_i) begin
                case (wb_adr_i)
                    `FBH_REG_CTRL: wb_dat_o <= ctrlImage;
                    `FBH_REG_ADDR: wb_dat_o <= {11'h0, addrReg};
                    `FBH_REG_WDATA: wb_dat_o <= {16'h0, wdataReg};
                    `FBH_REG_STAT: wb_dat_o <= statImage;
                    default: wb_dat_o <= 32'h0;
                endcase
            end
            // Settings are frozen while a cycle runs
            if (wbWr && !busy) begin
                case (wb_adr_i)
                    `FBH_REG_CTRL: begin
                        if (wb_sel_i[0]) begin
                            ctrlWrite <= wb_dat_i[`FBH_CTRL_WRITE];
                            ctrlWord <= wb_dat_i[`FBH_CTRL_WORD]; // R9
                            ctrlBootUnlock <= wb_dat_i[`FBH_CTRL_BOOTLOCK]; // R17 R18
                            ctrlFast <= wb_dat_i[`FBH_CTRL_FAST];
                            goReq <= wb_dat_i[`FBH_CTRL_GO];
                            rstReq <= wb_dat_i[`FBH_CTRL_RESET];
                        end
                    end
                    `FBH_REG_ADDR: begin
                        if (wb_sel_i[0]) addrReg[7:0] <= wb_dat_i[7:0];
                        if (wb_sel_i[1]) addrReg[15:8] <= wb_dat_i[15:8];
                        if (wb_sel_i[2]) addrReg[20:16] <= wb_dat_i[20:16];
                    end
                    `FBH_REG_WDATA: begin
                        if (wb_sel_i[0]) wdataReg[7:0] <= wb_dat_i[7:0];
                        if (wb_sel_i[1]) wdataReg[15:8] <= wb_dat_i[15:8];
                    end
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Pin sequencer
    // ------------------------------------------------------------
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            count <= 8'h0;
            rdataReg <= 16'h0;
            flashAddr <= 20'h0;
            flashDqOut <= 15'h0;
            flashDqOe <= 15'h0;
            topDataOrLowAddrOut <= 1'b0;
            topDataOrLowAddrOe <= 1'b0;
            chipSel_n <= 1'b1;
            outGate_n <= 1'b1;
            writeStrobe_n <= 1'b1;
            flashReset_n <= 1'b1;
            wordSel <= 1'b1;
            bootUnlock <= 1'b1;
        end else begin
            wordSel <= ctrlWord; // R1 R2
            bootUnlock <= ctrlBootUnlock; // R17 R18
            case (state)
                // Deselected, start the next request
                ST_IDLE: begin
                    chipSel_n <= 1'b1; // R14
                    outGate_n <= 1'b1; // R19
                    writeStrobe_n <= 1'b1;
                    flashDqOe <= 15'h0; // R21
                    topDataOrLowAddrOe <= 1'b0;
                    if (rstReq) begin
                        flashReset_n <= 1'b0; // R20 R5
                        count <= RP_CYC;
                        state <= ST_RST;
                    end else if (goReq) begin
                        // R3: word uses 20 bits, byte adds low half-word bit
                        if (ctrlWord) begin
                            flashAddr <= addrReg[19:0];
                        end else begin
                            flashAddr <= addrReg[20:1];
                            topDataOrLowAddrOut <= addrReg[0]; // R2
                            topDataOrLowAddrOe <= 1'b1;
                        end
                        chipSel_n <= 1'b0;
                        if (ctrlWrite) begin
                            // R8 R7 R10 R11: one command cycle per request
                            outGate_n <= 1'b1;
                            writeStrobe_n <= 1'b0;
                            flashDqOut <= ctrlWord ? wdataReg[14:0] : {7'h0, wdataReg[7:0]};
                            flashDqOe <= dqEnable(ctrlWord); // R9
                            if (ctrlWord) begin
                                topDataOrLowAddrOut <= wdataReg[15];
                                topDataOrLowAddrOe <= 1'b1;
                            end
                            count <= WP_CYC;
                            state <= ST_WRITE;
                        end else begin
                            // R4 R6 R12 R13
                            outGate_n <= 1'b0;
                            writeStrobe_n <= 1'b1;
                            count <= CE_CYC; // R15
                            state <= ST_READ;
                        end
                    end
                end
                // Hold select and gate for the access time
                ST_READ: begin
                    if (count > 8'h1) begin
                        count <= count - 8'h1;
                    end else begin
                        // R15: sample only after full access time
                        rdataReg <= ctrlWord ? {topDataOrLowAddrIn, flashDqIn} : {8'h0, flashDqIn[7:0]};
                        outGate_n <= 1'b1;
                        chipSel_n <= 1'b1; // R16
                        count <= HOLD_CYC;
                        state <= ST_HOLD;
                    end
                end
                // Hold the strobe low for its width
                ST_WRITE: begin
                    if (count > 8'h1) begin
                        count <= count - 8'h1;
                    end else begin
                        writeStrobe_n <= 1'b1; // Data latched on rising strobe
                        count <= HOLD_CYC;
                        state <= ST_HOLD;
                    end
                end
                // Keep data on the lines past the strobe
                ST_HOLD: begin
                    chipSel_n <= 1'b1;
                    if (count > 8'h1) begin
                        count <= count - 8'h1;
                    end else begin
                        flashDqOe <= 15'h0;
                        topDataOrLowAddrOe <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
                // Device reset pulse
                ST_RST: begin
                    if (count > 8'h1) begin
                        count <= count - 8'h1;
                    end else begin
                        flashReset_n <= 1'b1;
                        count <= RH_CYC;
                        state <= ST_RREC;
                    end
                end
                // Recovery before the next select
                ST_RREC: begin
                    if (count > 8'h1) begin
                        count <= count - 8'h1;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

endmodule

//--- hdl/fbh_defs.vh
// Constants for the parallel flash host controller
`ifndef FBH_DEFS_VH
`define FBH_DEFS_VH

// Register byte offsets on the Wishbone slave
`define FBH_REG_CTRL 4'h0
`define FBH_REG_ADDR 4'h4
`define FBH_REG_WDATA 4'h8
`define FBH_REG_STAT 4'hc

// Control register fields
`define FBH_CTRL_GO 0
`define FBH_CTRL_WRITE 1
`define FBH_CTRL_WORD 2
`define FBH_CTRL_BOOTLOCK 3
`define FBH_CTRL_RESET 4
`define FBH_CTRL_FAST 5

// Status register fields
`define FBH_STAT_BUSY 0
`define FBH_STAT_RDATA_LSB 16

// Timing, figures in ns, cycles at 8 ns rounded up
`define FBH_CLK_NS 8
`define FBH_T_CE_NS 70
`define FBH_T_WP_NS 35
`define FBH_T_HOLD_NS 20
`define FBH_T_RP_NS 500
`define FBH_T_RH_NS 200
`define FBH_CYC(ns) (((ns) + `FBH_CLK_NS - 1) / `FBH_CLK_NS)

// Widths
`define FBH_ADDR_W 21
`define FBH_CNT_W 8

`endif

//--- bench/fbh_flash_model.sv
// Behavioural parallel flash device facing the host controller
`timescale 1ns/1ps
module fbh_flash_model #(
    parameter logic [7:0] IDCODE = 8'h5a // Arbitrary value
) (
    input wire logic [19:0] addr, // Address lines
    input wire logic [15:0] dqIn, // Data lines as seen
    input wire logic ce_n, // Chip select
    input wire logic oe_n, // Output gate
    input wire logic we_n, // Write strobe
    input wire logic reset_n, // Device reset
    input wire logic word, // Width select
    output logic [15:0] dq, // Driven data
    output logic [15:0] dqOe // Driven enables
);
    logic [15:0] mem [16];
    logic idMode = 1'b0;
    logic ready = 1'b0;
    wire [15:0] wd = mem[addr[3:0]];
    wire rd = !ce_n && !oe_n && we_n && reset_n;
    // Preload
    initial for (int i = 0; i < 16; i++) mem[i] = 16'ha5c3 ^ (i * 16'h1111);
    // Data not valid until full select access time
    always @(ce_n) begin
        ready = 1'b0;
        if (!ce_n) #70 ready = !ce_n;
    end
    // Command latches, no address of their own
    always @(posedge we_n or negedge reset_n) begin
        if (!reset_n) idMode <= 1'b0;
        else if (!ce_n && oe_n) begin
            if (dqIn[7:0] == 8'h90) idMode <= 1'b1;
            else if (dqIn[7:0] == 8'hf0) idMode <= 1'b0;
            else if (word) mem[addr[3:0]] <= dqIn;
            else if (dqIn[15]) mem[addr[3:0]][15:8] <= dqIn[7:0];
            else mem[addr[3:0]][7:0] <= dqIn[7:0];
        end
    end
    // Output drive
    always @* begin
        dq = idMode ? {8'h00, IDCODE} : word ? wd : {8'h00, dqIn[15] ? wd[15:8] : wd[7:0]};
        if (!ready) dq = ~dq;
        dqOe = !rd ? 16'h0000 : word ? 16'hffff : 16'h00ff;
    end
endmodule

//--- bench/fbh_checker.sv
// Port checker for the flash host controller
`timescale 1ns/1ps
module fbh_checker (
    input wire logic sys_clk, // Clock
    input wire logic rst_n, // Reset
    input wire logic wb_cyc_i, // Cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_ack_o, // Acknowledge
    input wire logic [14:0] flashDqOe, // Data enables
    input wire logic topDataOrLowAddrOe, // Top line enable
    input wire logic chipSel_n, // Chip select
    input wire logic outGate_n, // Output gate
    input wire logic writeStrobe_n, // Write strobe
    input wire logic flashReset_n, // Device reset
    input wire logic wordSel // Width select
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence readHold;
        (!outGate_n && !chipSel_n)[*8];
    endsequence
    sequence strobeHold;
        (!writeStrobe_n)[*4] ##[1:3] writeStrobe_n;
    endsequence
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    read_levels_a: assert property (!outGate_n |-> !chipSel_n && writeStrobe_n && flashReset_n)
        else $error("bad read levels");
    write_levels_a: assert property (!writeStrobe_n |-> !chipSel_n && outGate_n && flashReset_n)
        else $error("bad write levels");
    no_contend_a: assert property (!outGate_n |-> flashDqOe == 15'h0 && !(wordSel && topDataOrLowAddrOe))
        else $error("host drives during read");
    byte_float_a: assert property (!wordSel |-> flashDqOe[14:8] == 7'h0) else $error("upper lines driven");
    read_access_a: assert property ($fell(outGate_n) |-> readHold) else $error("read too short");
    strobe_width_a: assert property ($fell(writeStrobe_n) |-> strobeHold) else $error("bad strobe");
    reset_idle_a: assert property (!flashReset_n |-> chipSel_n && outGate_n && writeStrobe_n)
        else $error("access in reset");
    reset_pulse_a: assert property ($fell(flashReset_n) |-> (!flashReset_n)[*8]) else $error("short reset");
endmodule

//--- bench/fbh_tb.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
module tb;
    logic sys_clk = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, junk = 0;
    logic [3:0] wb_adr_i = 0, wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 0, wb_dat_o, expQ[$], mskQ[$];
    logic wb_ack_o, chipSel_n, outGate_n, writeStrobe_n, flashReset_n, wordSel, bootUnlock;
    logic topDataOrLowAddrOut, topDataOrLowAddrOe, topDataOrLowAddrIn;
    logic [19:0] flashAddr;
    logic [14:0] flashDqOut, flashDqOe, flashDqIn;
    logic [15:0] devDq, devOe, hOe, bus;
    int num_errors = 0, n_checks = 0;
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) junk <= ~junk;
    // Wire level: host, device, else toggling float
    assign hOe = {topDataOrLowAddrOe, flashDqOe};
    assign bus = (hOe & {topDataOrLowAddrOut, flashDqOut}) | (~hOe & devOe & devDq) | (~hOe & ~devOe & {16{junk}});
    assign flashDqIn = bus[14:0];
    assign topDataOrLowAddrIn = bus[15];
    fbh_flash_host DUT (.*);
    fbh_flash_model #(.IDCODE(8'h5a)) FLASH (.addr(flashAddr), .dqIn(bus), .ce_n(chipSel_n), .oe_n(outGate_n),
        .we_n(writeStrobe_n), .reset_n(flashReset_n), .word(wordSel), .dq(devDq), .dqOe(devOe));
    function automatic logic [15:0] pre(input logic [19:0] x);
        return 16'ha5c3 ^ (x[3:0] * 16'h1111);
    endfunction
    task automatic cmp(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
        if (m == 0) return;
        n_checks++;
        if ((g & m) !== (e & m)) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g & m, e & m);
        end
    endtask
    // Result watcher
    always @(posedge sys_clk) if (wb_ack_o === 1'b1 && !wb_we_i && expQ.size() > 0)
        cmp(wb_dat_o, expQ.pop_front(), mskQ.pop_front());
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int t;
        t = 0;
        @(posedge sys_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1 && t++ < 50);
        if (wb_ack_o !== 1'b1) num_errors++;
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [31:0] e, input logic [31:0] m, output logic [31:0] q);
        expQ.push_back(e);
        mskQ.push_back(m);
        wb(0, 4'hc, 0, q);
    endtask
    task automatic op(input logic [7:0] c, input logic [31:0] ad, input logic [15:0] d);
        logic [31:0] q;
        int t;
        t = 0;
        wb(1, 4'h4, ad, q);
        wb(1, 4'h8, {16'h0, d}, q);
        wb(1, 4'h0, {24'h0, c}, q);
        do rd(0, 0, q); while (q[0] !== 1'b0 && t++ < 200);
        if (q[0] !== 1'b0) num_errors++;
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        final_report;
    end
    initial begin
        logic [31:0] q;
        logic [19:0] a;
        logic [15:0] d;
        logic [7:0] b;
        void'($urandom(32'he9ff));
        repeat (4) @(posedge sys_clk);
        rst_n <= 1;
        a = $urandom;
        d = $urandom & 16'hff7f;
        b = $urandom & 8'h7f;
        op(8'h05, {12'h0, a}, 0);
        cmp({31'h0, bootUnlock}, 0, 1);
        rd({pre(a), 16'h0}, 32'hffff0000, q);
        $display("test power-up read done");
        op(8'h0f, {12'h0, a}, d);
        op(8'h0d, {12'h0, a}, 0);
        cmp({31'h0, bootUnlock}, 1, 1);
        rd({d, 16'h0}, 32'hffff0000, q);
        for (int i = 0; i < 2; i++) begin
            op(8'h09, {11'h0, a, i[0]}, 0);
            rd({8'h0, d[8 * i +: 8], 16'h0}, 32'h00ff0000, q);
        end
        op(8'h0b, {11'h0, a, 1'b1}, {8'h0, b});
        expQ.push_back({11'h0, a, 1'b1});
        mskQ.push_back(32'h001fffff);
        wb(0, 4'h4, 0, q);
        op(8'h0d, {12'h0, a}, 0);
        rd({b, d[7:0], 16'h0}, 32'hffff0000, q);
        $display("test width modes done");
        wb(1, 4'h0, 32'h20, q);
        expQ.push_back(32'h20);
        mskQ.push_back(32'h3f);
        wb(0, 4'h0, 0, q);
        op(8'h0f, {12'h0, a}, 16'h0090);
        op(8'h0d, {12'h0, a}, 0);
        rd({8'h0, 8'h5a, 16'h0}, 32'h00ff0000, q);
        op(8'h0f, {12'h0, a}, 16'h00f0);
        op(8'h0d, {12'h0, a}, 0);
        rd({b, d[7:0], 16'h0}, 32'hffff0000, q);
        op(8'h0f, {12'h0, a}, 16'h0090);
        op(8'h1d, {12'h0, a}, 0);
        op(8'h0d, {12'h0, a}, 0);
        rd({b, d[7:0], 16'h0}, 32'hffff0000, q);
        $display("test command modes done");
        final_report;
    end
endmodule
bind fbh_flash_host fbh_checker chk (.*);
